// ==== rtl/byte_bus_bridge.sv ====
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module byte_bus_bridge (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// register bus
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// transfers from the chip side
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire byte_bridge_pkg::req_s      req,
	output logic                            resp_valid,
	input  wire logic                       resp_ready,
	output byte_bridge_pkg::resp_s          resp,
	// byte bus pins
	input  wire logic                       boot_internal_clock,
	output logic                            bus_clk_out,
	output logic                            bus_clk_oe,
	output logic [23:0]                     byte_addr_out,
	output logic                            byte_addr_oe,
	input  wire logic [7:0]                 byte_data_in,
	output logic [7:0]                      byte_data_out,
	output logic                            byte_data_oe,
	output byte_bridge_pkg::cmd_lines_s     cmd_lines_out,
	output logic                            cmd_lines_oe,
	output logic                            global_chip_select_n,
	output logic                            global_chip_select_oe
);
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WAIT, S_STROBE, S_HOLD, S_RESP} state_e;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [5:0] base_ff;
	logic [2:0] wait_ff;
	logic       enable_ff;
	logic [4:0] div_ff;
	logic       int_clk_ff;

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        aw_have_ff, w_have_ff;

	wire aw_take  = s_axi_awvalid & awready_ff;
	wire w_take   = s_axi_wvalid & wready_ff;
	wire aw_now   = aw_have_ff | aw_take;
	wire w_now    = w_have_ff | w_take;
	wire [7:0]  wr_addr = aw_take ? s_axi_awaddr : awaddr_ff;
	wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_ff;
	wire [3:0]  wr_strb = w_take ? s_axi_wstrb : wstrb_ff;
	wire do_write = aw_now & w_now & ~bvalid_ff;
	wire wr_ctrl  = do_write & (wr_addr == byte_bridge_pkg::CTRL_OFFSET);
	wire wr_known = (wr_addr == byte_bridge_pkg::CTRL_OFFSET) |
	                (wr_addr == byte_bridge_pkg::STATUS_OFFSET);
	wire ar_take  = s_axi_arvalid & arready_ff;

	state_e     state_ff, nxt_state;
	logic [7:0] last_byte_ff;

	wire [31:0] ctrl_word = {base_ff, 15'h0000, wait_ff, enable_ff, 2'h0, div_ff};
	wire [31:0] status_word = {16'h0000, last_byte_ff, 5'h00,
	                           int_clk_ff, enable_ff, (state_ff != S_IDLE)};
	wire [31:0] rd_mux = (s_axi_araddr == byte_bridge_pkg::CTRL_OFFSET)   ? ctrl_word :
	                     (s_axi_araddr == byte_bridge_pkg::STATUS_OFFSET) ? status_word :
	                     32'h0000_0000;
	wire rd_known = (s_axi_araddr == byte_bridge_pkg::CTRL_OFFSET) |
	                (s_axi_araddr == byte_bridge_pkg::STATUS_OFFSET);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= byte_bridge_pkg::RESP_OKAY;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (aw_take) begin
				awaddr_ff  <= s_axi_awaddr;
				awready_ff <= 1'b0;
				aw_have_ff <= 1'b1;
			end
			if (w_take) begin
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
				wready_ff <= 1'b0;
				w_have_ff <= 1'b1;
			end
			if (do_write) begin
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_known ? byte_bridge_pkg::RESP_OKAY : byte_bridge_pkg::RESP_SLVERR;
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
			end
			if (bvalid_ff & s_axi_bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= byte_bridge_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_mux;
			rresp_ff   <= rd_known ? byte_bridge_pkg::RESP_OKAY : byte_bridge_pkg::RESP_SLVERR;
		end else if (rvalid_ff & s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// strap is caught by the clocked reset branch, never asynchronously
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_ff    <= byte_bridge_pkg::BASE_RESET;
			wait_ff    <= byte_bridge_pkg::WAIT_RESET;
			enable_ff  <= byte_bridge_pkg::ENABLE_RESET;
			div_ff     <= byte_bridge_pkg::DIV_RESET;
			int_clk_ff <= boot_internal_clock;
		end else if (wr_ctrl) begin
			if (wr_strb[3])
				base_ff <= wr_data[byte_bridge_pkg::BASE_MSB:byte_bridge_pkg::BASE_LSB];
			if (wr_strb[1])
				wait_ff <= wr_data[byte_bridge_pkg::WAIT_MSB:byte_bridge_pkg::WAIT_LSB];
			if (wr_strb[0]) begin
				enable_ff <= wr_data[byte_bridge_pkg::ENABLE_BIT];
				div_ff    <= wr_data[byte_bridge_pkg::DIV_MSB:byte_bridge_pkg::DIV_LSB];
			end
		end
	end

	// ----------------------------------------------------------------
	// byte cycle sequencer
	// ----------------------------------------------------------------
	byte_bridge_pkg::req_s  cur_ff;
	byte_bridge_pkg::resp_s result_ff;
	logic [2:0] ws_cnt_ff;
	logic       req_ready_ff;
	logic       buf_in_ready;

	wire take    = req_valid & req_ready_ff;
	wire hit     = enable_ff & (req.addr[byte_bridge_pkg::BASE_MSB:byte_bridge_pkg::BASE_LSB] == base_ff);
	wire ws_zero = (ws_cnt_ff == 3'h0);
	wire [23:0] cur_baddr = cur_ff.addr[25:2];

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:   if (take) nxt_state = hit ? S_SETUP : S_RESP;
			S_SETUP:  nxt_state = (cur_ff.write && wait_ff != 3'h0) ? S_WAIT : S_STROBE;
			S_WAIT:   if (ws_zero) nxt_state = S_STROBE;
			S_STROBE: if (cur_ff.write) nxt_state = S_HOLD;
			          else if (ws_zero) nxt_state = S_RESP;
			S_HOLD:   nxt_state = S_RESP;
			S_RESP:   if (buf_in_ready) nxt_state = S_IDLE;
			default:  nxt_state = S_IDLE;
		endcase
	end

	// pins follow the next state so every pin is a flop output
	wire active    = (nxt_state == S_SETUP) | (nxt_state == S_WAIT) |
	                 (nxt_state == S_STROBE) | (nxt_state == S_HOLD);
	wire strobe    = (nxt_state == S_STROBE);
	wire nxt_write = (state_ff == S_IDLE) ? req.write : cur_ff.write;
	wire [3:0] nxt_lines = (nxt_state == S_SETUP) ?
	                       (nxt_write ? byte_bridge_pkg::WRITE_PATTERN :
	                                    byte_bridge_pkg::READ_PATTERN) :
	                       strobe ? {2'b10, ~nxt_write, nxt_write} :
	                       byte_bridge_pkg::LINES_IDLE;
	wire [31:0] nxt_addr = (state_ff == S_IDLE) ? req.addr : cur_ff.addr;
	wire [31:0] nxt_wdat = (state_ff == S_IDLE) ? req.wdata : cur_ff.wdata;

	logic [23:0] addr_out_ff;
	logic [7:0]  data_out_ff;
	logic        addr_oe_ff, data_oe_ff, lines_oe_ff, cs_n_ff, cs_oe_ff;
	logic [3:0]  lines_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff     <= S_IDLE;
			cur_ff       <= '0;
			result_ff    <= '0;
			ws_cnt_ff    <= 3'h0;
			req_ready_ff <= 1'b1;
			last_byte_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (take) begin
				cur_ff       <= req;
				req_ready_ff <= 1'b0;
				result_ff    <= '{err: ~hit, data: 32'h0000_0000};
			end
			if (state_ff == S_SETUP)
				ws_cnt_ff <= cur_ff.write ? wait_ff - 3'h1 : wait_ff;
			else if (!ws_zero)
				ws_cnt_ff <= ws_cnt_ff - 3'h1;
			if (state_ff == S_STROBE && !cur_ff.write && ws_zero) begin
				result_ff.data <= {byte_data_in, cur_baddr};
				last_byte_ff   <= byte_data_in;
			end
			if (state_ff == S_RESP && buf_in_ready)
				req_ready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_out_ff <= 24'h000000;
			addr_oe_ff  <= 1'b0;
			data_out_ff <= 8'h00;
			data_oe_ff  <= 1'b0;
			lines_ff    <= byte_bridge_pkg::LINES_IDLE;
			lines_oe_ff <= 1'b0;
			cs_n_ff     <= 1'b1;
			cs_oe_ff    <= 1'b0;
		end else begin
			addr_out_ff <= nxt_addr[25:2];
			addr_oe_ff  <= active;
			data_out_ff <= nxt_wdat[byte_bridge_pkg::BYTE_MSB:byte_bridge_pkg::BYTE_LSB];
			data_oe_ff  <= active & nxt_write;
			lines_ff    <= nxt_lines;
			lines_oe_ff <= active;
			cs_n_ff     <= ~active;
			cs_oe_ff    <= active;
		end
	end

	// ----------------------------------------------------------------
	// answer path and bus clock
	// ----------------------------------------------------------------
	// two entries so a stalled receiver never loses a finished byte
	resp_buffer #(
		.WIDTH (33),
		.DEPTH (2)
	) u_resp_buffer (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (state_ff == S_RESP),
		.in_ready  (buf_in_ready),
		.in_data   (result_ff),
		.out_valid (resp_valid),
		.out_ready (resp_ready),
		.out_data  (resp)
	);

	bus_clock_gen u_bus_clock_gen (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.run           (int_clk_ff),
		.divider       (div_ff),
		.bus_clk_ff    (bus_clk_out),
		.bus_clk_oe_ff (bus_clk_oe)
	);

	assign s_axi_awready         = awready_ff;
	assign s_axi_wready          = wready_ff;
	assign s_axi_bvalid          = bvalid_ff;
	assign s_axi_bresp           = bresp_ff;
	assign s_axi_arready         = arready_ff;
	assign s_axi_rvalid          = rvalid_ff;
	assign s_axi_rdata           = rdata_ff;
	assign s_axi_rresp           = rresp_ff;
	assign req_ready             = req_ready_ff;
	assign byte_addr_out         = addr_out_ff;
	assign byte_addr_oe          = addr_oe_ff;
	assign byte_data_out         = data_out_ff;
	assign byte_data_oe          = data_oe_ff;
	assign cmd_lines_out         = lines_ff;
	assign cmd_lines_oe          = lines_oe_ff;
	assign global_chip_select_n  = cs_n_ff;
	assign global_chip_select_oe = cs_oe_ff;
endmodule

// ==== include/byte_bridge_pkg.sv ====
// How it works
// - every transfer offered on the request port is taken, one at a time; req_ready stays low until its answer is queued.
// - a read answers {bus byte, 24-bit bus address}.
// - a write drives only data bits 31:24 onto the byte bus; the low 24 bits are dropped.
// - the byte-bus address is the word offset above the base, i.e. request address bits 25:2.
// - a 3-bit code inserts exactly 0 to 7 wait states into every byte cycle.
// - byte cycles never run back to back; the bus is released for at least two cycles between them; wait states are added inside each byte cycle.
// - on reads, strobe stays low together with read enable for 1 + wait-state cycles; read enable is already low in setup.
// - on writes, write enable and strobe go low only after the wait states.
// - outside a byte cycle every output enable but bus_clk_oe is low and the byte bus is released.
// - each byte moves as one whole request word; the initiator counts four per byte.
// - control register: base 31:26, wait states 10:8, enable 7, divider 4:0 (reset 0x1f).
// - with internal clocking strapped, bus clock period is divider + 1 clocks; divider 0 stops it.
// - byte-enable lines carry 0110 (read) or 0111 (write) in setup; lines 0,1,2 are rd, wr, strobe.
// - global chip select is low while a byte cycle is active.
package byte_bridge_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;
	localparam int          BASE_MSB      = 31;
	localparam int          BASE_LSB      = 26;
	localparam int          WAIT_MSB      = 10;
	localparam int          WAIT_LSB      = 8;
	localparam int          ENABLE_BIT    = 7;
	localparam int          DIV_MSB       = 4;
	localparam int          DIV_LSB       = 0;
	localparam logic [5:0]  BASE_RESET    = 6'h00;
	localparam logic [2:0]  WAIT_RESET    = 3'h0;
	localparam logic        ENABLE_RESET  = 1'b0;
	localparam logic [4:0]  DIV_RESET     = 5'h1f;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ----------------------------------------------------------------
	// byte-enable patterns and data layout
	// ----------------------------------------------------------------
	localparam logic [3:0]  READ_PATTERN  = 4'h6;
	localparam logic [3:0]  WRITE_PATTERN = 4'h7;
	localparam logic [3:0]  LINES_IDLE    = 4'hf;
	localparam int          ADDR_W        = 24;
	localparam int          BYTE_MSB      = 31;
	localparam int          BYTE_LSB      = 24;

	typedef struct packed {
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} req_s;

	typedef struct packed {
		logic        err;
		logic [31:0] data;
	} resp_s;

	// bit 3 unused, 2 strobe, 1 write enable, 0 read enable; all active low
	typedef struct packed {
		logic spare_n;
		logic byte_strobe_n;
		logic byte_write_enable_n;
		logic byte_read_enable_n;
	} cmd_lines_s;
endpackage

// ==== rtl/resp_buffer.sv ====
`timescale 1ns/1ps
module resp_buffer #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 2
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ff;
	logic [PW-1:0]    rd_ff;
	logic [PW:0]      cnt_ff;
	logic             valid_ff;
	logic [WIDTH-1:0] head_ff;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;
	wire [PW:0]   nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
	wire [PW-1:0] nxt_rd  = !pop ? rd_ff : (rd_ff == PW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;

	assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
	// head word held in a register; a push into the head slot bypasses the array
	assign out_valid = valid_ff;
	assign out_data  = head_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff   <= '0;
			valid_ff <= 1'b0;
			head_ff  <= '0;
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data;
				wr_ff         <= (wr_ff == PW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			end
			rd_ff    <= nxt_rd;
			cnt_ff   <= nxt_cnt;
			valid_ff <= (nxt_cnt != '0);
			head_ff  <= (push && wr_ff == nxt_rd) ? in_data : mem_ff[nxt_rd];
		end
	end
endmodule

// ==== rtl/bus_clock_gen.sv ====
`timescale 1ns/1ps
module bus_clock_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [4:0] divider,
	output logic            bus_clk_ff,
	output logic            bus_clk_oe_ff
);
	logic [4:0] cnt_ff;

	// high for the first half of divider+1 counts; odd divider gives 50% duty
	wire [4:0] half   = 5'((6'(divider) + 6'h01) >> 1);
	wire       legal  = run & (divider != 5'h00);
	wire       wrap   = (cnt_ff >= divider);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff        <= 5'h00;
			bus_clk_ff    <= 1'b0;
			bus_clk_oe_ff <= 1'b0;
		end else begin
			bus_clk_oe_ff <= run;
			if (!legal) begin
				cnt_ff     <= 5'h00;
				bus_clk_ff <= 1'b0;
			end else begin
				cnt_ff     <= wrap ? 5'h00 : cnt_ff + 5'h01;
				bus_clk_ff <= wrap | (cnt_ff + 5'h01 < half);
			end
		end
	end
endmodule

// ==== bench/byte_bus_bridge_properties.sv ====
`timescale 1ns/1ps
module byte_bus_bridge_properties (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic [7:0]                  s_axi_awaddr,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic [31:0]                 s_axi_wdata,
	input wire logic [3:0]                  s_axi_wstrb,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        req_valid,
	input wire logic                        req_ready,
	input wire byte_bridge_pkg::req_s       req,
	input wire logic                        resp_valid,
	input wire logic [23:0]                 byte_addr_out,
	input wire logic                        byte_addr_oe,
	input wire logic [7:0]                  byte_data_out,
	input wire logic                        byte_data_oe,
	input wire byte_bridge_pkg::cmd_lines_s cmd_lines_out,
	input wire logic                        cmd_lines_oe,
	input wire logic                        global_chip_select_n,
	input wire logic                        global_chip_select_oe
);
	// ----
	// shadow of the wait code and of the request in flight
	// ----
	logic [2:0]  wait_ff;
	logic [3:0]  rd_cnt_ff;
	logic [3:0]  wr_cnt_ff;
	logic [31:0] addr_ff;
	logic [7:0]  byte_ff;
	// setup already pulls read enable low, so the read phase is counted by strobe too
	wire rd_low = cmd_lines_oe && !cmd_lines_out.byte_read_enable_n
		&& !cmd_lines_out.byte_strobe_n;
	wire wr_low = cmd_lines_oe && !cmd_lines_out.byte_write_enable_n;
	// assumes address and data arrive at one edge, as the bench offers them
	wire ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == byte_bridge_pkg::CTRL_OFFSET && s_axi_wstrb[1];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_ff <= byte_bridge_pkg::WAIT_RESET;
			rd_cnt_ff <= 4'h0;
			wr_cnt_ff <= 4'h0;
		end else begin
			if (ctrl_wr)
				wait_ff <= s_axi_wdata[byte_bridge_pkg::WAIT_MSB:byte_bridge_pkg::WAIT_LSB];
			rd_cnt_ff <= rd_low ? rd_cnt_ff + 4'h1 : 4'h0;
			wr_cnt_ff <= !cmd_lines_oe ? 4'h0 : wr_cnt_ff + {3'h0, !wr_low};
		end
	end
	always_ff @(posedge aclk) begin
		if (req_valid && req_ready) begin
			addr_ff <= req.addr;
			byte_ff <= req.wdata[31:24];
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	select_with_lines_a: assert property (
		cmd_lines_oe |-> !global_chip_select_n && global_chip_select_oe && byte_addr_oe)
		else $error("chip select or address not driven during byte cycle");
	release_idle_a: assert property (
		!global_chip_select_oe |-> !cmd_lines_oe && !byte_data_oe && !byte_addr_oe)
		else $error("bus driven outside byte cycle");
	setup_pattern_a: assert property (
		$rose(cmd_lines_oe) |-> cmd_lines_out == (byte_data_oe ?
			byte_bridge_pkg::WRITE_PATTERN : byte_bridge_pkg::READ_PATTERN))
		else $error("wrong setup pattern on command lines");
	read_strobe_len_a: assert property (
		$fell(rd_low) |-> rd_cnt_ff == {1'b0, wait_ff} + 4'h1)
		else $error("read enable low for wrong cycle count");
	write_delay_a: assert property (
		$rose(wr_low) |-> wr_cnt_ff == {1'b0, wait_ff} + 4'h1)
		else $error("write enable delayed by wrong cycle count");
	strobe_pairs_a: assert property (
		cmd_lines_oe && !cmd_lines_out.byte_strobe_n |->
			cmd_lines_out.byte_read_enable_n != cmd_lines_out.byte_write_enable_n)
		else $error("strobe low without exactly one enable");
	write_byte_a: assert property (
		wr_low |-> byte_data_oe && byte_data_out == byte_ff)
		else $error("write byte not the top data byte");
	addr_map_a: assert property (
		cmd_lines_oe |-> byte_addr_out == addr_ff[25:2])
		else $error("byte address not the word offset");
	take_answer_a: assert property (
		req_valid && req_ready |=> !req_ready ##[0:20] resp_valid)
		else $error("request not held off or not answered");
	reg_write_resp_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
			s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("register write not answered next cycle");
endmodule

bind byte_bus_bridge byte_bus_bridge_properties u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .resp_valid(resp_valid), .byte_addr_out(byte_addr_out),
	.byte_addr_oe(byte_addr_oe), .byte_data_out(byte_data_out), .byte_data_oe(byte_data_oe),
	.cmd_lines_out(cmd_lines_out), .cmd_lines_oe(cmd_lines_oe),
	.global_chip_select_n(global_chip_select_n), .global_chip_select_oe(global_chip_select_oe));

// ==== bench/byte_device_model.sv ====
`timescale 1ns/1ps
module byte_device_model (
	input  wire logic                        aclk,
	input  wire logic [23:0]                 byte_addr,
	input  wire logic [7:0]                  data_out,
	input  wire logic                        data_oe,
	input  wire byte_bridge_pkg::cmd_lines_s lines,
	input  wire logic                        lines_oe,
	input  wire logic                        select_n,
	input  wire logic                        select_oe,
	output logic [7:0]                       data_wire
);
	// ----
	// released control lines read high through pull-ups
	// ----
	logic [7:0] mem [256];
	logic [7:0] last_ff = 8'h00;
	wire rd_n = lines_oe ? lines.byte_read_enable_n : 1'b1;
	wire wr_n = lines_oe ? lines.byte_write_enable_n : 1'b1;
	wire ds_n = lines_oe ? lines.byte_strobe_n : 1'b1;
	wire cs_n = select_oe ? select_n : 1'b1;
	wire drive = !cs_n && !rd_n && !ds_n;
	// floating data lines flip each cycle so a stale byte is never mistaken for data
	assign data_wire = data_oe ? data_out : drive ? mem[byte_addr[7:0]] : ~last_ff;
	always @(posedge aclk) begin
		last_ff <= data_wire;
		if (!cs_n && !wr_n && !ds_n)
			mem[byte_addr[7:0]] <= data_wire;
	end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, req_valid, req_ready, resp_valid, resp_ready;
	logic        boot_internal_clock, bus_clk_out, bus_clk_oe, byte_addr_oe, byte_data_oe;
	logic        cmd_lines_oe, global_chip_select_n, global_chip_select_oe;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, byte_data_in, byte_data_out;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [23:0] byte_addr_out;
	byte_bridge_pkg::req_s       req;
	byte_bridge_pkg::resp_s      resp;
	byte_bridge_pkg::cmd_lines_s cmd_lines_out;
	int          mismatches, checks_done, cycles, hi, lo;
	logic        took;

	byte_bus_bridge u_dut (.*);
	byte_device_model u_dev (.aclk(aclk), .byte_addr(byte_addr_out), .data_out(byte_data_out),
		.data_oe(byte_data_oe), .lines(cmd_lines_out), .lines_oe(cmd_lines_oe),
		.select_n(global_chip_select_n), .select_oe(global_chip_select_oe),
		.data_wire(byte_data_in));

	// ----
	// access tasks
	// ----
	function automatic logic [31:0] pa(input logic [23:0] b);
		return {6'h16, b, 2'b00};
	endfunction
	function automatic logic [31:0] ctl(input logic [2:0] w);
		return {6'h16, 15'h0000, w, 1'b1, 2'h0, 5'h03};
	endfunction
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && !aw_done) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_done) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check({32'h0, s_axi_bresp}, {32'h0, byte_bridge_pkg::RESP_OKAY});
	endtask
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic send(input logic w, input logic [31:0] a, input logic [31:0] d);
		req <= {w, a, d};
		req_valid <= 1'b1;
		do @(posedge aclk); while (!req_ready);
		req_valid <= 1'b0;
		@(posedge aclk);
	endtask
	// resp_ready is held by the caller, so a response is taken at the edge it is seen
	task automatic recv(input logic w, input logic e, input logic [31:0] x);
		do @(posedge aclk); while (!resp_valid);
		if (w)
			check({33'h0, resp.err}, {33'h0, e});
		else
			check({1'b0, resp}, {1'b0, e, x});
	endtask
	task automatic final_report;
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report;
		end
	end

	// ----
	// test sequence
	// ----
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_valid} = 49'h0;
		s_axi_wstrb = 4'hf;
		req = '0;
		resp_ready = 1'b1;
		boot_internal_clock = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(byte_bridge_pkg::CTRL_OFFSET);
		check({rr, rd}, {byte_bridge_pkg::RESP_OKAY, byte_bridge_pkg::BASE_RESET, 15'h0000,
			byte_bridge_pkg::WAIT_RESET, byte_bridge_pkg::ENABLE_RESET, 2'h0,
			byte_bridge_pkg::DIV_RESET});
		axi_rd(8'h10);
		check({rr, rd}, {byte_bridge_pkg::RESP_SLVERR, 32'h00000000});
		send(1'b0, pa(24'h000011), 32'h0);
		recv(1'b0, 1'b1, 32'h0);
		for (int w = 0; w < 8; w++) begin
			axi_wr(byte_bridge_pkg::CTRL_OFFSET, ctl(w[2:0]));
			send(1'b1, pa(24'h110012 + w[23:0]), {8'ha0 + w[7:0], 24'habcdef});
			recv(1'b1, 1'b0, 32'h0);
			send(1'b0, pa(24'h110012 + w[23:0]), 32'h0);
			recv(1'b0, 1'b0, {8'ha0 + w[7:0], 24'h110012 + w[23:0]});
		end
		axi_rd(byte_bridge_pkg::CTRL_OFFSET);
		check({rr, rd}, {byte_bridge_pkg::RESP_OKAY, ctl(3'h7)});
		// status: last read byte, internal clock, enable, idle
		axi_rd(byte_bridge_pkg::STATUS_OFFSET);
		check({rr, rd}, {byte_bridge_pkg::RESP_OKAY, 32'h0000a706});
		send(1'b0, {6'h15, 24'h000011, 2'b00}, 32'h0);
		recv(1'b0, 1'b1, 32'h0);
		do @(posedge aclk); while (bus_clk_out !== 1'b0);
		do @(posedge aclk); while (bus_clk_out !== 1'b1);
		for (hi = 0; bus_clk_out === 1'b1; hi++) @(posedge aclk);
		for (lo = 0; bus_clk_out === 1'b0; lo++) @(posedge aclk);
		check(hi, 2);
		check(hi + lo, 4);
		check({33'h0, bus_clk_oe}, 34'h1);
		axi_wr(byte_bridge_pkg::CTRL_OFFSET, ctl(3'h2));
		resp_ready <= 1'b0;
		for (int i = 0; i < 3; i++)
			send(1'b0, pa(24'h110012 + i[23:0]), 32'h0);
		req <= {1'b0, pa(24'h110015), 32'h0};
		req_valid <= 1'b1;
		took = 1'b0;
		repeat (20) begin
			@(posedge aclk);
			took = took | req_ready;
		end
		check({33'h0, took}, 34'h0);
		resp_ready <= 1'b1;
		for (int i = 0; i < 3; i++)
			recv(1'b0, 1'b0, {8'ha0 + i[7:0], 24'h110012 + i[23:0]});
		while (!req_ready) @(posedge aclk);
		req_valid <= 1'b0;
		recv(1'b0, 1'b0, {8'ha3, 24'h110015});
		final_report;
	end
endmodule
